// ### prsd_params.svh
// Constants for the PLL reference switch and divider control block.
// Assumes an 8-bit register port with a 10-bit address.
`ifndef PRSD_PARAMS_SVH
`define PRSD_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PRSD_ADDR_W        10
`define PRSD_OFS_R_LO      10'h011
`define PRSD_OFS_R_HI      10'h012
`define PRSD_OFS_A_CNT     10'h013
`define PRSD_OFS_B_LO      10'h014
`define PRSD_OFS_B_HI      10'h015
`define PRSD_OFS_PRESC     10'h016
`define PRSD_OFS_ALIGN     10'h019
`define PRSD_OFS_REF_CTL   10'h01C
`define PRSD_OFS_RST_CTL   10'h01E
`define PRSD_OFS_STATUS    10'h01F

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PRSD_REF_DIFF      0
`define PRSD_REF_PRI_EN    1
`define PRSD_REF_SEC_EN    2
`define PRSD_REF_STAY      3
`define PRSD_REF_AUTO      4
`define PRSD_REF_PIN_SEL   5
`define PRSD_REF_REG_SEC   6
`define PRSD_REF_DGL_OFF   7
`define PRSD_RST_R         0
`define PRSD_RST_AB        1
`define PRSD_RST_SHARED    2
`define PRSD_RST_RDLY_EN   3
`define PRSD_RST_NDLY_EN   4

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define PRSD_RST_VAL_BYTE  8'h00
`define PRSD_RST_B_LO      8'h03
`define PRSD_MISS_FALLS    2'd2
`define PRSD_REVERT_RISES  3'd4

`endif

// ### prsd_pkg.sv
// Types for the PLL reference switch and divider control block.
// Assumes prsd_params.svh is compiled alongside.
`default_nettype none

package prsd_pkg;

    typedef enum logic [0:0] {
        ST_RUN,
        ST_HOLD
    } prsd_sw_e;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [9:0]  addr;
        logic [7:0]  wdata;
    } prsd_req_s;

    typedef struct packed {
        logic [5:0] p;
        logic       dm;
    } prsd_presc_s;

endpackage

`default_nettype wire

// ### prsd_pll_ref_switch.sv
// Reference monitor, switchover, R divider and P/A/B feedback divider.
// Assumes all pins are synchronous to clk and far slower than it.
//
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "prsd_params.svh"

module prsd_pll_ref_switch #(
    parameter int BW = 13,
    parameter int AW = 6
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              srst,
    // Register port
    input  wire prsd_pkg::prsd_req_s busReq,
    output logic [7:0]             rdData,
    // Reference, feedback, select and align pins
    input  wire logic              primaryRef,
    input  wire logic              secondaryRef,
    input  wire logic              refSelPin,
    input  wire logic              alignN,
    input  wire logic              vcoIn,
    // Reference and divider outputs
    output logic                   pllRefOut,
    output logic                   rDivOut,
    output logic                   nDivOut,
    // Status and analog controls
    output logic                   usingSecondary,
    output logic                   primaryMissing,
    output logic                   priBufPd,
    output logic                   secBufPd,
    output logic                   rDelayEn,
    output logic [2:0]             rDelaySel,
    output logic                   nDelayEn,
    output logic [2:0]             nDelaySel
);

    if (BW < 2 || BW > 13 || AW < 1 || AW > 6) begin : g_chk
        $error("prsd_pll_ref_switch: BW must be 2..13 and AW 1..6");
    end

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [7:0] rLo_r, rHi_r, aReg_r, bLo_r, bHi_r, presc_r;
    logic [7:0] align_r, refCtl_r, rstCtl_r, rdNxt;
    logic       primaryMissing_r, selSec_r, autoSec_r;
    prsd_pkg::prsd_sw_e state_r;

    always_ff @(posedge clk) begin
        if (srst) begin
            rLo_r    <= `PRSD_RST_VAL_BYTE;
            rHi_r    <= `PRSD_RST_VAL_BYTE;
            aReg_r   <= `PRSD_RST_VAL_BYTE;
            bLo_r    <= `PRSD_RST_B_LO;
            bHi_r    <= `PRSD_RST_VAL_BYTE;
            presc_r  <= `PRSD_RST_VAL_BYTE;
            align_r  <= `PRSD_RST_VAL_BYTE;
            refCtl_r <= `PRSD_RST_VAL_BYTE;
            rstCtl_r <= `PRSD_RST_VAL_BYTE;
        end else if (busReq.wr) begin
            case (busReq.addr)
                `PRSD_OFS_R_LO:    rLo_r    <= busReq.wdata;
                `PRSD_OFS_R_HI:    rHi_r    <= {2'b00, busReq.wdata[5:0]};
                `PRSD_OFS_A_CNT:   aReg_r   <= {2'b00, busReq.wdata[5:0]};
                `PRSD_OFS_B_LO:    bLo_r    <= busReq.wdata;
                `PRSD_OFS_B_HI:    bHi_r    <= {3'b000, busReq.wdata[4:0]};
                `PRSD_OFS_PRESC:   presc_r  <= {5'b00000, busReq.wdata[2:0]};
                `PRSD_OFS_ALIGN:   align_r  <= busReq.wdata;
                `PRSD_OFS_REF_CTL: refCtl_r <= busReq.wdata;
                `PRSD_OFS_RST_CTL: rstCtl_r <= {3'b000, busReq.wdata[4:0]};
                default: ;
            endcase
        end
    end

    always_comb begin
        rdNxt = 8'h00;
        case (busReq.addr)
            `PRSD_OFS_R_LO:    rdNxt = rLo_r;
            `PRSD_OFS_R_HI:    rdNxt = rHi_r;
            `PRSD_OFS_A_CNT:   rdNxt = aReg_r;
            `PRSD_OFS_B_LO:    rdNxt = bLo_r;
            `PRSD_OFS_B_HI:    rdNxt = bHi_r;
            `PRSD_OFS_PRESC:   rdNxt = presc_r;
            `PRSD_OFS_ALIGN:   rdNxt = align_r;
            `PRSD_OFS_REF_CTL: rdNxt = refCtl_r;
            `PRSD_OFS_RST_CTL: rdNxt = rstCtl_r;
            `PRSD_OFS_STATUS:  rdNxt = {5'b00000, state_r == prsd_pkg::ST_HOLD, primaryMissing_r, selSec_r};
            default:           rdNxt = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rdData <= 8'h00;
        end else begin
            rdData <= busReq.rd ? rdNxt : 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------
    logic priPrev_r, secPrev_r, vcoPrev_r;
    logic priEdge, priRise, secFall, secRise, vcoRise;

    always_ff @(posedge clk) begin
        if (srst) begin
            priPrev_r <= 1'b0;
            secPrev_r <= 1'b0;
            vcoPrev_r <= 1'b0;
        end else begin
            priPrev_r <= primaryRef;
            secPrev_r <= secondaryRef;
            vcoPrev_r <= vcoIn;
        end
    end

    assign priEdge = primaryRef ^ priPrev_r;
    assign priRise = primaryRef & ~priPrev_r;
    assign secFall = ~secondaryRef & secPrev_r;
    assign secRise = secondaryRef & ~secPrev_r;
    assign vcoRise = vcoIn & ~vcoPrev_r;

    // ------------------------------------------------------------
    // Primary monitor
    // ------------------------------------------------------------
    logic       diffMode, autoOn, stayOnSec, deglitchOff, manualSec, wantSec;
    logic       missSet, missClr;
    logic [1:0] secFalls_r, between_r;
    logic [2:0] revCnt_r;

    assign diffMode    = refCtl_r[`PRSD_REF_DIFF];
    assign autoOn      = refCtl_r[`PRSD_REF_AUTO] & ~diffMode;
    assign stayOnSec   = refCtl_r[`PRSD_REF_STAY];
    assign deglitchOff = refCtl_r[`PRSD_REF_DGL_OFF];
    assign manualSec   = refCtl_r[`PRSD_REF_PIN_SEL] ? refSelPin : refCtl_r[`PRSD_REF_REG_SEC];
    assign missSet     = !primaryMissing_r && secFall && !priEdge
                         && (secFalls_r == `PRSD_MISS_FALLS - 2'd1);
    assign missClr     = primaryMissing_r && priRise
                         && (revCnt_r == `PRSD_REVERT_RISES - 3'd1);

    always_ff @(posedge clk) begin
        if (srst || !autoOn) begin
            secFalls_r       <= 2'd0;
            between_r        <= 2'd0;
            revCnt_r         <= 3'd0;
            primaryMissing_r <= 1'b0;
        end else begin
            if (priEdge) begin
                secFalls_r <= 2'd0;
            end else if (secFall && secFalls_r != `PRSD_MISS_FALLS) begin
                secFalls_r <= secFalls_r + 2'd1;
            end
            if (missSet) begin
                primaryMissing_r <= 1'b1;
                revCnt_r         <= 3'd0;
                between_r        <= 2'd0;
            end else if (primaryMissing_r) begin
                if (priRise) begin
                    revCnt_r  <= missClr ? 3'd0 : revCnt_r + 3'd1;
                    between_r <= 2'd0;
                    if (missClr) begin
                        primaryMissing_r <= 1'b0;
                    end
                end else if (secFall) begin
                    if (between_r == `PRSD_MISS_FALLS - 2'd1) begin
                        revCnt_r  <= 3'd0;
                        between_r <= 2'd0;
                    end else begin
                        between_r <= between_r + 2'd1;
                    end
                end
            end
        end
    end

    // Outside auto mode the auto choice shadows the manual one
    always_ff @(posedge clk) begin
        if (srst) begin
            autoSec_r <= 1'b0;
        end else if (!autoOn) begin
            autoSec_r <= manualSec;
        end else if (missSet) begin
            autoSec_r <= 1'b1;
        end else if (missClr && !stayOnSec) begin
            autoSec_r <= 1'b0;
        end
    end

    assign wantSec = diffMode ? 1'b0 : (autoOn ? autoSec_r : manualSec);

    // ------------------------------------------------------------
    // Deglitched switchover
    // ------------------------------------------------------------
    logic newRise, refLevel;

    assign newRise  = wantSec ? secRise : priRise;
    assign refLevel = (state_r == prsd_pkg::ST_RUN) ? (selSec_r ? secondaryRef : primaryRef) : 1'b0;

    always_ff @(posedge clk) begin
        if (srst) begin
            state_r  <= prsd_pkg::ST_RUN;
            selSec_r <= 1'b0;
        end else begin
            case (state_r)
                prsd_pkg::ST_RUN: begin
                    if (wantSec != selSec_r) begin
                        if (deglitchOff) begin
                            selSec_r <= wantSec;
                        end else begin
                            state_r <= prsd_pkg::ST_HOLD;
                        end
                    end
                end
                prsd_pkg::ST_HOLD: begin
                    if (wantSec == selSec_r) begin
                        state_r <= prsd_pkg::ST_RUN;
                    end else if (newRise || deglitchOff) begin
                        selSec_r <= wantSec;
                        state_r  <= prsd_pkg::ST_RUN;
                    end
                end
                default: state_r <= prsd_pkg::ST_RUN;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Reset sources
    // ------------------------------------------------------------
    logic syncHold, rReset, abReset;

    assign syncHold = (align_r[7:6] != 2'b00) && !alignN;
    assign rReset   = rstCtl_r[`PRSD_RST_R] | rstCtl_r[`PRSD_RST_SHARED] | syncHold;
    assign abReset  = rstCtl_r[`PRSD_RST_AB] | rstCtl_r[`PRSD_RST_SHARED] | syncHold;

    // ------------------------------------------------------------
    // Reference divider
    // ------------------------------------------------------------
    logic [13:0] rVal, rEff, rCnt_r;
    logic        refRise;

    assign rVal    = {rHi_r[5:0], rLo_r};
    assign rEff    = (rVal < 14'd2) ? 14'd1 : rVal;
    assign refRise = refLevel & ~pllRefOut;

    always_ff @(posedge clk) begin
        if (srst || rReset) begin
            rCnt_r  <= 14'd0;
            rDivOut <= 1'b0;
        end else if (refRise) begin
            if (rCnt_r >= rEff - 14'd1) begin
                rCnt_r  <= 14'd0;
                rDivOut <= 1'b1;
            end else begin
                rCnt_r  <= rCnt_r + 14'd1;
                rDivOut <= 1'b0;
            end
        end else begin
            rDivOut <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Feedback divider: prescaler with A and B counters
    // ------------------------------------------------------------
    function automatic prsd_pkg::prsd_presc_s decodePresc(input logic [2:0] mode);
        prsd_pkg::prsd_presc_s d;
        d.dm = 1'b1;
        case (mode)
            3'd0:    begin d.p = 6'd1;  d.dm = 1'b0; end
            3'd1:    begin d.p = 6'd2;  d.dm = 1'b0; end
            3'd2:    d.p = 6'd2;
            3'd3:    d.p = 6'd4;
            3'd4:    d.p = 6'd8;
            3'd5:    d.p = 6'd16;
            3'd6:    d.p = 6'd32;
            default: begin d.p = 6'd3;  d.dm = 1'b0; end
        endcase
        return d;
    endfunction

    prsd_pkg::prsd_presc_s presc;
    logic [BW-1:0] bVal, bEff, bCnt_r;
    logic [AW-1:0] aEff, aLeft_r, aNext;
    logic [5:0]    preCnt_r;

    assign presc = decodePresc(presc_r[2:0]);
    assign bVal  = BW'({bHi_r[4:0], bLo_r});
    assign bEff  = (bVal == '0) ? BW'(1) : bVal;
    assign aEff  = (presc.dm && bEff != BW'(1)) ? aReg_r[AW-1:0] : '0;
    assign aNext = (aLeft_r != '0) ? aLeft_r - AW'(1) : '0;

    always_ff @(posedge clk) begin
        if (srst || abReset) begin
            bCnt_r   <= bEff - BW'(1);
            aLeft_r  <= aEff;
            preCnt_r <= (aEff != '0) ? presc.p : presc.p - 6'd1;
            nDivOut  <= 1'b0;
        end else if (vcoRise) begin
            if (preCnt_r != 6'd0) begin
                preCnt_r <= preCnt_r - 6'd1;
                nDivOut  <= 1'b0;
            end else if (bCnt_r == '0) begin
                bCnt_r   <= bEff - BW'(1);
                aLeft_r  <= aEff;
                preCnt_r <= (aEff != '0) ? presc.p : presc.p - 6'd1;
                nDivOut  <= 1'b1;
            end else begin
                bCnt_r   <= bCnt_r - BW'(1);
                aLeft_r  <= aNext;
                preCnt_r <= (aNext != '0) ? presc.p : presc.p - 6'd1;
                nDivOut  <= 1'b0;
            end
        end else begin
            nDivOut <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            pllRefOut      <= 1'b0;
            usingSecondary <= 1'b0;
            primaryMissing <= 1'b0;
            priBufPd       <= 1'b1;
            secBufPd       <= 1'b1;
            rDelayEn       <= 1'b0;
            rDelaySel      <= 3'd0;
            nDelayEn       <= 1'b0;
            nDelaySel      <= 3'd0;
        end else begin
            pllRefOut      <= refLevel;
            usingSecondary <= selSec_r;
            primaryMissing <= primaryMissing_r;
            priBufPd       <= diffMode | ~refCtl_r[`PRSD_REF_PRI_EN];
            secBufPd       <= diffMode | ~refCtl_r[`PRSD_REF_SEC_EN];
            rDelayEn       <= rstCtl_r[`PRSD_RST_RDLY_EN];
            rDelaySel      <= align_r[5:3];
            nDelayEn       <= rstCtl_r[`PRSD_RST_NDLY_EN];
            nDelaySel      <= align_r[2:0];
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    logic [18:0] vcoSeen_r;
    logic        cfgQuiet_r;
    logic [18:0] nExpect;

    assign nExpect = 19'(presc.p) * 19'(bEff) + 19'(aEff);

    always_ff @(posedge clk) begin
        if (srst || abReset || nDivOut) begin
            vcoSeen_r  <= 19'd0;
            cfgQuiet_r <= !(srst || abReset || busReq.wr);
        end else begin
            vcoSeen_r  <= vcoSeen_r + 19'(vcoRise);
            cfgQuiet_r <= cfgQuiet_r && !busReq.wr;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence pendSwitch;
        autoOn && autoSec_r && !selSec_r && state_r == prsd_pkg::ST_HOLD && !deglitchOff;
    endsequence

    sequence secEdge;
        secRise && wantSec;
    endsequence

    miss_declare_a: assert property ($rose(primaryMissing_r) |-> $past(secFall) && !$past(priEdge))
        else $error("primary declared missing without a secondary fall");
    diff_no_switch_a: assert property (diffMode && !selSec_r && state_r == prsd_pkg::ST_RUN |=> !selSec_r)
        else $error("secondary selected in differential mode");
    switch_on_rise_a: assert property (pendSwitch ##0 secEdge |=> selSec_r)
        else $error("switch to secondary missed its rising edge");
    deglitch_edge_a: assert property ($rose(selSec_r) && !$past(deglitchOff) |-> $past(secRise))
        else $error("deglitched switch not aligned to new reference");
    revert_four_a: assert property ($fell(primaryMissing_r) && autoOn |-> $past(revCnt_r) == 3'd3)
        else $error("primary return declared early");
    stay_sec_a: assert property (autoOn && stayOnSec && autoSec_r && !missSet ##1 autoOn |-> autoSec_r)
        else $error("left secondary while stay mode set");
    rdiv_one_a: assert property (rEff == 14'd1 && refRise && !rReset |=> rDivOut)
        else $error("divide-by-one reference missed a pulse");
    ab_hold_a: assert property (abReset [*2] |-> !nDivOut)
        else $error("feedback divider ran while held in reset");
    sync_hold_a: assert property (syncHold |=> !rDivOut && !nDivOut)
        else $error("align pin did not hold counters");
    ndiv_ratio_a: assert property (nDivOut && cfgQuiet_r && !$past(busReq.wr) |-> vcoSeen_r == nExpect)
        else $error("feedback divide ratio wrong");

endmodule

`default_nettype wire

// ### prsd_ref_model.sv
// Source model: two reference clocks and the VCO feedback clock.
// Assumes clk is the block clock; every pin edge lands after it.
`timescale 1ns/10ps
`default_nettype none

module prsd_ref_model #(
    parameter int PH = 3,
    parameter int SH = 4,
    parameter int VH = 2
) (
    // Clock and source enables
    input  wire logic clk,
    input  wire logic priOn,
    input  wire logic secOn,
    // Driven pins
    output logic      primaryRef,
    output logic      secondaryRef,
    output logic      vcoIn
);
    int   pc      = 0;
    int   sc      = 0;
    int   vc      = 0;
    logic pri_r   = 1'b0;
    logic sec_r   = 1'b0;
    logic vco_r   = 1'b0;

    assign primaryRef   = pri_r;
    assign secondaryRef = sec_r;
    assign vcoIn        = vco_r;

    // A stopped source holds a driven low level, never floats
    always @(posedge clk) begin
        pc <= (pc == PH - 1) ? 0 : pc + 1;
        sc <= (sc == SH - 1) ? 0 : sc + 1;
        vc <= (vc == VH - 1) ? 0 : vc + 1;
        if (!priOn)
            pri_r <= 1'b0;
        else if (pc == PH - 1)
            pri_r <= ~pri_r;
        if (!secOn)
            sec_r <= 1'b0;
        else if (sc == SH - 1)
            sec_r <= ~sec_r;
        if (vc == VH - 1)
            vco_r <= ~vco_r;
    end
endmodule

`default_nettype wire

// ### tb_pll_ref_switch_and_dividers.sv
// Self-checking bench for the reference switch and divider block.
// Assumes prsd_ref_model: primary period 6, secondary 8, VCO 4 clocks.
`timescale 1ns/10ps
`default_nettype none
`include "prsd_params.svh"

module tb_pll_ref_switch_and_dividers;
    logic clk = 1'b0;
    logic srst = 1'b1;
    prsd_pkg::prsd_req_s busReq = '0;
    logic refSelPin = 1'b0;
    logic alignN = 1'b1;
    logic priOn = 1'b1;
    logic secOn = 1'b1;
    logic primaryRef, secondaryRef, vcoIn, pllRefOut, rDivOut, nDivOut;
    logic usingSecondary, primaryMissing, priBufPd, secBufPd, rDelayEn, nDelayEn;
    logic [2:0] rDelaySel, nDelaySel;
    logic [7:0] rdData;
    logic [7:0] selTab [4] = '{8'h26, 8'h06, 8'h46, 8'h06};
    int errors = 0;
    int nTests = 0;

    always #2.5 clk = ~clk;

    prsd_ref_model i_prsd_ref_model (.clk(clk), .priOn(priOn), .secOn(secOn),
        .primaryRef(primaryRef), .secondaryRef(secondaryRef), .vcoIn(vcoIn));

    prsd_pll_ref_switch i_prsd_pll_ref_switch (.clk(clk), .srst(srst), .busReq(busReq),
        .rdData(rdData), .primaryRef(primaryRef), .secondaryRef(secondaryRef),
        .refSelPin(refSelPin), .alignN(alignN), .vcoIn(vcoIn), .pllRefOut(pllRefOut),
        .rDivOut(rDivOut), .nDivOut(nDivOut), .usingSecondary(usingSecondary),
        .primaryMissing(primaryMissing), .priBufPd(priBufPd), .secBufPd(secBufPd),
        .rDelayEn(rDelayEn), .rDelaySel(rDelaySel), .nDelayEn(nDelayEn), .nDelaySel(nDelaySel));

    task reportAndStop;
        $display("comparisons %0d mismatches %0d", nTests, errors);
        if (errors == 0 && nTests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task chk(input logic [15:0] g, input logic [15:0] e);
        nTests++;
        if (g !== e) begin
            errors++;
            $display("[ERR] t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    task wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk);
        busReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        busReq <= '0;
    endtask

    task rdc(input logic [9:0] a, input logic [7:0] e);
        @(posedge clk);
        busReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        busReq <= '0;
        #1;
        chk({8'h00, rdData}, {8'h00, e});
    endtask

    // Cycles between the second and third output pulse; 0 if fewer than three come
    task meas(input bit useR, output int c);
        int k, seen;
        seen = 0;
        c = 0;
        for (k = 0; k < 4000 && seen < 3; k++) begin
            @(posedge clk);
            #1;
            if (seen == 2)
                c++;
            if (useR ? rDivOut : nDivOut)
                seen++;
        end
        if (seen < 3)
            c = 0;
    endtask

    function automatic logic sig(input int s);
        return s ? primaryMissing : usingSecondary;
    endfunction

    task waitSig(input int s, input logic v, input int lim);
        int k;
        for (k = 0; k < lim && sig(s) !== v; k++) begin
            @(posedge clk);
            #1;
        end
        chk({15'h0000, sig(s)}, {15'h0000, v});
    endtask

    function automatic int expN(input int md, input int a, input int b);
        int p;
        p = (md == 0) ? 1 : (md == 1) ? 2 : (md == 7) ? 3 : 2 << (md - 2);
        if (b == 1)
            return p;
        return (md < 2 || md == 7) ? p * b : p * b + a;
    endfunction

    initial begin
        #(5 * 95000);
        errors++;
        reportAndStop;
    end

    initial begin
        int m, md, a, b, r, d, c;
        void'($urandom(32'he14d_2bac));
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        #1;
        chk({priBufPd, secBufPd}, 2'b11);
        rdc(`PRSD_OFS_B_LO, 8'h03);
        rdc(`PRSD_OFS_REF_CTL, 8'h00);
        rdc(10'h3FF, 8'h00);
        $display("test reset done");
        // Feedback divider over every prescaler mode, then bypassed B
        for (m = 0; m < 10; m++) begin
            md = (m == 8) ? 0 : (m == 9) ? 4 : m;
            b = (m > 7) ? 1 : 3 + $urandom_range(5);
            a = (m == 2) ? 0 : $urandom_range(b - 1);
            wr(`PRSD_OFS_A_CNT, 8'(a));
            wr(`PRSD_OFS_B_LO, 8'(b));
            wr(`PRSD_OFS_PRESC, 8'(md));
            meas(1'b0, c);
            chk(16'(c), 16'(4 * expN(md, a, b)));
        end
        // Reference divider on the manually chosen primary
        wr(`PRSD_OFS_REF_CTL, 8'h06);
        wr(`PRSD_OFS_R_HI, 8'hFF);
        rdc(`PRSD_OFS_R_HI, 8'h3F);
        wr(`PRSD_OFS_R_HI, 8'h00);
        for (m = 0; m < 4; m++) begin
            r = (m < 2) ? m : 2 + $urandom_range(12);
            wr(`PRSD_OFS_R_LO, 8'(r));
            meas(1'b1, c);
            chk(16'(c), 16'(6 * ((r < 2) ? 1 : r)));
        end
        $display("test dividers done");
        // Reset bits hold their counters until written back
        wr(`PRSD_OFS_R_LO, 8'h03);
        wr(`PRSD_OFS_A_CNT, 8'h00);
        wr(`PRSD_OFS_B_LO, 8'h03);
        wr(`PRSD_OFS_PRESC, 8'h01);
        for (m = 0; m < 3; m++) begin
            wr(`PRSD_OFS_RST_CTL, 8'(1 << m));
            meas(1'b1, c);
            chk(16'(c), (m == 1) ? 16'h0012 : 16'h0000);
            meas(1'b0, c);
            chk(16'(c), (m == 0) ? 16'h0018 : 16'h0000);
            rdc(`PRSD_OFS_RST_CTL, 8'(1 << m));
        end
        wr(`PRSD_OFS_RST_CTL, 8'h00);
        @(posedge clk);
        alignN <= 1'b0;
        meas(1'b1, c);
        chk(16'(c), 16'h0012);
        wr(`PRSD_OFS_ALIGN, 8'hC0);
        meas(1'b1, c);
        chk(16'(c), 16'h0000);
        meas(1'b0, c);
        chk(16'(c), 16'h0000);
        @(posedge clk);
        alignN <= 1'b1;
        // Delay cell controls
        d = $urandom_range(63);
        wr(`PRSD_OFS_ALIGN, 8'(d));
        wr(`PRSD_OFS_RST_CTL, 8'h18);
        @(posedge clk);
        #1;
        chk({rDelayEn, rDelaySel, nDelayEn, nDelaySel}, {1'b1, 3'(d >> 3), 1'b1, 3'(d)});
        wr(`PRSD_OFS_RST_CTL, 8'h00);
        wr(`PRSD_OFS_ALIGN, 8'h00);
        $display("test resets done");
        // Manual selection by pin, then by register with the pin ignored
        @(posedge clk);
        refSelPin <= 1'b1;
        for (m = 0; m < 4; m++) begin
            wr(`PRSD_OFS_REF_CTL, selTab[m]);
            waitSig(0, selTab[m][5] | selTab[m][6], 60);
        end
        @(posedge clk);
        refSelPin <= 1'b0;
        // Automatic switching, revertive
        wr(`PRSD_OFS_REF_CTL, 8'h16);
        @(posedge clk);
        priOn <= 1'b0;
        waitSig(1, 1'b1, 60);
        waitSig(0, 1'b1, 40);
        rdc(`PRSD_OFS_STATUS, 8'h03);
        @(posedge clk);
        priOn <= 1'b1;
        waitSig(0, 1'b0, 80);
        waitSig(1, 1'b0, 5);
        // Stay on secondary until manual reselect, then auto again
        wr(`PRSD_OFS_REF_CTL, 8'h1E);
        @(posedge clk);
        priOn <= 1'b0;
        waitSig(0, 1'b1, 100);
        @(posedge clk);
        priOn <= 1'b1;
        repeat (150) @(posedge clk);
        #1;
        waitSig(0, 1'b1, 1);
        wr(`PRSD_OFS_REF_CTL, 8'h06);
        waitSig(0, 1'b0, 60);
        wr(`PRSD_OFS_REF_CTL, 8'h1E);
        repeat (100) @(posedge clk);
        #1;
        waitSig(0, 1'b0, 1);
        $display("test switching done");
        // Deglitch holds the output low while the target is silent
        @(posedge clk);
        secOn <= 1'b0;
        wr(`PRSD_OFS_REF_CTL, 8'h46);
        repeat (50) @(posedge clk);
        #1;
        chk({14'h0000, pllRefOut, usingSecondary}, 16'h0000);
        wr(`PRSD_OFS_REF_CTL, 8'hC6);
        waitSig(0, 1'b1, 5);
        @(posedge clk);
        secOn <= 1'b1;
        chk({14'h0000, priBufPd, secBufPd}, 16'h0000);
        // Differential mode: no auto switching, buffers off
        wr(`PRSD_OFS_REF_CTL, 8'h17);
        waitSig(0, 1'b0, 60);
        @(posedge clk);
        priOn <= 1'b0;
        repeat (100) @(posedge clk);
        #1;
        chk({priBufPd, secBufPd, usingSecondary}, 3'b110);
        $display("test modes done");
        reportAndStop;
    end
endmodule

`default_nettype wire
